//--- hdl/lat_defs.svh
// Register offsets, field positions, reset values and level constants
`ifndef LAT_DEFS_SVH
`define LAT_DEFS_SVH
`define LAT_TSEL_FIRST 8'h41
`define LAT_TSEL_LAST 8'h57
`define LAT_LOFS_LO 8'h5A
`define LAT_LOFS_HI 8'h5B
`define LAT_SAT 8'h60
`define LAT_CON 8'h61
`define LAT_BRI 8'h62
`define LAT_RGAIN 8'h63
`define LAT_ROFS 8'h64
`define LAT_RTSEL 8'h65
`define LAT_XPSEL 8'h66
`define LAT_STATUS 8'h67
`define LAT_LOFS8_BIT 4
`define LAT_FOFS_BIT 7
`define LAT_SAT_RST 8'h40
`define LAT_CON_RST 8'h44
`define LAT_BRI_RST 8'h80
`define LAT_RGAIN_RST 8'h40
`define LAT_ROFS_RST 8'h80
`define LAT_TSEL_RST 8'hFF
`define LAT_SEL_RST 8'h00
`define LAT_Y_DIV 19'sh00044
`define LAT_UV_DIV 19'sh00040
`define LAT_MID 8'h80
`define LAT_MIN 8'h01
`define LAT_MAX 8'hFE
`define LAT_TYPE_VBI_YUV 4'h6
`define LAT_TYPE_ACT_YUV 4'hF
`define LAT_ENTRY_FIRST 5'h02
`define LAT_ENTRY_LAST 5'h17
`define LAT_ENTRY_REST 5'h18
`define LAT_SYNC_FF 8'hFF
`define LAT_SYNC_00 8'h00
`endif

//--- hdl/lat_pkg.sv
// Types shared by the level adjust and line typer block
package lat_pkg;
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] uv;
		logic [7:0] comp;
	} lat_sample_t;
	typedef struct packed {
		logic raw;
		logic [7:0] y;
		logic [7:0] uv;
	} lat_word_t;
	typedef struct packed {
		logic href;
		logic v123;
		logic vgate;
		logic fid;
		logic f656;
	} lat_ref_t;
	typedef enum logic [2:0] {
		LAT_IDLE, LAT_PRE1, LAT_PRE2, LAT_XY, LAT_LUMA
	} lat_fmt_t;
endpackage : lat_pkg

//--- hdl/lat_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
module lat_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic push, pop;

	always_comb begin
		in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
		out_valid = wr_reg != rd_reg;
		out_data = mem_reg[rd_reg[AW-1:0]];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wr_reg[AW-1:0]] <= in_data;
		end
	end
endmodule : lat_fifo

//--- hdl/lat_line_typer.sv
// Level adjust, line typer and expansion port formatter of the decoder
`include "lat_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Function
// RL1: Chroma out is int(saturation_gain/64 times (uv minus 128)) plus 128.
// RL2: Luma out is int(contrast_gain/68 times (y minus 128)) plus brightness.
// RL3: Raw out is int(raw_gain/64 times (comp minus 128)) plus raw_offset.
// RL4: Every luma, chroma and raw sample is clamped to 1..254.
// RL5: Contrast, brightness, saturation reset to 44H, 80H, 40H.
// RL6: Raw gain resets to 64 and raw offset to 128.
// RL7: Raw and VBI strobes follow the line type selected for this line.
// RL8: Entries 2..23 name single lines; entry 24 covers the rest.
// RL9: Upper nibble types field 1, lower nibble types field 2.
// RL10: Nine-bit line offset and field offset flag shift the line mapping.
// RL11: Software uses offset 03H/flag 0 at 50 Hz, 06H/flag 1 at 60 Hz.
// RL12: Types 6 and 15 give YUV 4:2:2, all others give raw.
// RL13: A formatter puts data on the 8-bit expansion port in 656 form.
// RL14: Selectable reference signals drive real-time and expansion outputs.
// RL15: VBI and raw lines always bypass the chroma comb filter.
// RL16: Products are full precision, truncated, offset, then clamped.
module lat_line_typer
	import lat_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Line timing from sync stage
	input wire logic [8:0] line_num,
	input wire logic field_id,
	input wire logic line_start,
	input wire lat_ref_t refs,
	// Decoded samples
	input wire logic in_valid,
	output logic in_ready,
	input wire lat_sample_t in_sample,
	// Line type strobes
	output logic raw_line_strobe,
	output logic vbi_line_strobe,
	output logic comb_bypass,
	// Expansion port
	output logic [7:0] expansion_port_data,
	output logic expansion_data_qualifier,
	input wire logic xp_ready,
	output logic expansion_horiz_ref,
	output logic expansion_vert_ref,
	// Real-time port
	output logic realtime_control_out,
	output logic realtime_select_out0,
	output logic realtime_select_out1
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lat_adjust(input logic [7:0] s,
		input logic [7:0] g, input logic [7:0] o, input logic signed [18:0] dv);
		logic signed [9:0] d;
		logic signed [18:0] p;
		logic signed [19:0] r;
		d = $signed({2'b00, s}) - 10'sh080;
		p = $signed({1'b0, g}) * d;
		p = p / dv; // RL16
		r = $signed({p[18], p}) + $signed({12'h000, o}); // RL16
		if (r < $signed({12'h000, `LAT_MIN})) begin // RL4
			lat_adjust = `LAT_MIN;
		end else if (r > $signed({12'h000, `LAT_MAX})) begin
			lat_adjust = `LAT_MAX;
		end else begin
			lat_adjust = r[7:0];
		end
	endfunction : lat_adjust

	function automatic logic lat_is_yuv(input logic [3:0] t);
		lat_is_yuv = (t == `LAT_TYPE_VBI_YUV) || (t == `LAT_TYPE_ACT_YUV);
	endfunction : lat_is_yuv

	function automatic logic lat_pick(input lat_ref_t r, input logic [2:0] s);
		case (s)
			3'h0: lat_pick = r.href;
			3'h1: lat_pick = r.v123;
			3'h2: lat_pick = r.vgate;
			3'h3: lat_pick = r.fid;
			3'h4: lat_pick = r.f656;
			default: lat_pick = 1'b0;
		endcase
	endfunction : lat_pick

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0] tsel_reg [2:24];
	logic [7:0] tsel_next [2:24];
	logic [7:0] lofs_lo_reg, lofs_lo_next, lofs_hi_reg, lofs_hi_next;
	logic [7:0] sat_reg, sat_next, con_reg, con_next, bri_reg, bri_next;
	logic [7:0] rgain_reg, rgain_next, rofs_reg, rofs_next;
	logic [7:0] rtsel_reg, rtsel_next, xpsel_reg, xpsel_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [3:0] cur_type;
	logic cur_yuv;
	logic [4:0] entry;
	logic [8:0] rel;
	logic field_sel;
	logic tsel_hit;
	logic [4:0] tsel_idx;

	always_comb begin
		tsel_hit = reg_addr >= `LAT_TSEL_FIRST && reg_addr <= `LAT_TSEL_LAST;
		tsel_idx = 5'(reg_addr - `LAT_TSEL_FIRST) + `LAT_ENTRY_FIRST;
		for (int i = 2; i <= 24; i++) begin
			tsel_next[i] = (reg_wr && tsel_hit && tsel_idx == 5'(i)) ?
				reg_wdata : tsel_reg[i];
		end
		lofs_lo_next = (reg_wr && reg_addr == `LAT_LOFS_LO) ? reg_wdata
			: lofs_lo_reg;
		lofs_hi_next = (reg_wr && reg_addr == `LAT_LOFS_HI) ? reg_wdata
			: lofs_hi_reg;
		sat_next = (reg_wr && reg_addr == `LAT_SAT) ? reg_wdata : sat_reg;
		con_next = (reg_wr && reg_addr == `LAT_CON) ? reg_wdata : con_reg;
		bri_next = (reg_wr && reg_addr == `LAT_BRI) ? reg_wdata : bri_reg;
		rgain_next = (reg_wr && reg_addr == `LAT_RGAIN) ? reg_wdata
			: rgain_reg;
		rofs_next = (reg_wr && reg_addr == `LAT_ROFS) ? reg_wdata : rofs_reg;
		rtsel_next = (reg_wr && reg_addr == `LAT_RTSEL) ? reg_wdata
			: rtsel_reg;
		xpsel_next = (reg_wr && reg_addr == `LAT_XPSEL) ? reg_wdata
			: xpsel_reg;
		rdata_next = rdata_reg;
		if (reg_rd) begin
			case (reg_addr)
				`LAT_LOFS_LO: rdata_next = lofs_lo_reg;
				`LAT_LOFS_HI: rdata_next = lofs_hi_reg;
				`LAT_SAT: rdata_next = sat_reg;
				`LAT_CON: rdata_next = con_reg;
				`LAT_BRI: rdata_next = bri_reg;
				`LAT_RGAIN: rdata_next = rgain_reg;
				`LAT_ROFS: rdata_next = rofs_reg;
				`LAT_RTSEL: rdata_next = rtsel_reg;
				`LAT_XPSEL: rdata_next = xpsel_reg;
				`LAT_STATUS: rdata_next = {2'b00, raw_line_strobe,
					vbi_line_strobe, cur_type};
				default: rdata_next = tsel_hit ? tsel_reg[tsel_idx] : 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 2; i <= 24; i++) begin
				tsel_reg[i] <= `LAT_TSEL_RST;
			end
			lofs_lo_reg <= `LAT_SEL_RST;
			lofs_hi_reg <= `LAT_SEL_RST;
			sat_reg <= `LAT_SAT_RST; // RL5
			con_reg <= `LAT_CON_RST; // RL5
			bri_reg <= `LAT_BRI_RST; // RL5
			rgain_reg <= `LAT_RGAIN_RST; // RL6
			rofs_reg <= `LAT_ROFS_RST; // RL6
			rtsel_reg <= `LAT_SEL_RST;
			xpsel_reg <= `LAT_SEL_RST;
			rdata_reg <= 8'h00;
		end else begin
			for (int i = 2; i <= 24; i++) begin
				tsel_reg[i] <= tsel_next[i];
			end
			lofs_lo_reg <= lofs_lo_next;
			lofs_hi_reg <= lofs_hi_next;
			sat_reg <= sat_next;
			con_reg <= con_next;
			bri_reg <= bri_next;
			rgain_reg <= rgain_next;
			rofs_reg <= rofs_next;
			rtsel_reg <= rtsel_next;
			xpsel_reg <= xpsel_next;
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Line type lookup
	always_comb begin
		rel = line_num - {lofs_hi_reg[`LAT_LOFS8_BIT], lofs_lo_reg}; // RL10
		field_sel = field_id ^ lofs_hi_reg[`LAT_FOFS_BIT]; // RL10
		if (rel >= 9'(`LAT_ENTRY_FIRST) && rel <= 9'(`LAT_ENTRY_LAST)) begin
			entry = rel[4:0]; // RL8
		end else begin
			entry = `LAT_ENTRY_REST; // RL8
		end
		cur_type = field_sel ? tsel_reg[entry][3:0] : tsel_reg[entry][7:4]; // RL9
		cur_yuv = lat_is_yuv(cur_type); // RL12
	end

	////////////////////////////////////////////////////////////////////////
	// Strobes and reference selection
	logic raw_reg, raw_next, vbi_reg, vbi_next, byp_reg, byp_next;
	logic [4:0] sel_reg, sel_next;

	always_comb begin
		raw_next = !cur_yuv; // RL7
		vbi_next = cur_type != `LAT_TYPE_ACT_YUV; // RL7
		byp_next = raw_next || vbi_next; // RL15
		sel_next[0] = lat_pick(refs, rtsel_reg[2:0]); // RL14
		sel_next[1] = lat_pick(refs, rtsel_reg[5:3]); // RL14
		sel_next[2] = lat_pick(refs, {1'b0, rtsel_reg[7:6]}); // RL14
		sel_next[3] = lat_pick(refs, xpsel_reg[2:0]); // RL14
		sel_next[4] = lat_pick(refs, xpsel_reg[5:3]); // RL14
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			raw_reg <= 1'b0;
			vbi_reg <= 1'b0;
			byp_reg <= 1'b0;
			sel_reg <= '0;
		end else begin
			raw_reg <= raw_next;
			vbi_reg <= vbi_next;
			byp_reg <= byp_next;
			sel_reg <= sel_next;
		end
	end
	assign raw_line_strobe = raw_reg;
	assign vbi_line_strobe = vbi_reg;
	assign comb_bypass = byp_reg;
	assign realtime_select_out0 = sel_reg[0];
	assign realtime_select_out1 = sel_reg[1];
	assign realtime_control_out = sel_reg[2];
	assign expansion_horiz_ref = sel_reg[3];
	assign expansion_vert_ref = sel_reg[4];

	////////////////////////////////////////////////////////////////////////
	// Level adjust stage
	lat_word_t st_reg, st_next;
	logic st_vld_reg, st_vld_next;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	lat_word_t fifo_out;
	logic accept;

	always_comb begin
		in_ready = !st_vld_reg || fifo_in_ready;
		accept = in_valid && in_ready;
		st_next = st_reg;
		st_vld_next = in_ready ? in_valid : st_vld_reg;
		if (accept) begin
			st_next.raw = !cur_yuv;
			if (cur_yuv) begin
				st_next.y = lat_adjust(in_sample.y, con_reg, bri_reg,
					`LAT_Y_DIV); // RL2
				st_next.uv = lat_adjust(in_sample.uv, sat_reg, `LAT_MID,
					`LAT_UV_DIV); // RL1
			end else begin
				st_next.y = lat_adjust(in_sample.comp, rgain_reg, rofs_reg,
					`LAT_UV_DIV); // RL3
				st_next.uv = `LAT_MID;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_vld_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			st_vld_reg <= st_vld_next;
		end
	end

	lat_fifo #(
		.WIDTH($bits(lat_word_t)),
		.DEPTH(4)
	) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(st_vld_reg),
		.in_ready(fifo_in_ready),
		.in_data(st_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Expansion port formatter: SAV code per line, then Cb/Cr, Y bytes per YUV sample or one byte per raw sample
	lat_fmt_t fmt_reg, fmt_next;
	logic [7:0] xd_reg, xd_next, xy_reg, xy_next;
	logic xv_reg, xv_next, pend_reg, pend_next, fire;

	always_comb begin
		fire = !xv_reg || xp_ready;
		fmt_next = fmt_reg;
		xd_next = xd_reg;
		xv_next = fire ? 1'b0 : xv_reg;
		fifo_pop = 1'b0;
		pend_next = pend_reg;
		xy_next = xy_reg;
		if (line_start) begin
			xy_next = {1'b1, field_id, vbi_next, 1'b0, vbi_next, field_id,
				field_id ^ vbi_next, field_id ^ vbi_next};
		end
		if (fire) begin
			case (fmt_reg)
				LAT_IDLE: begin
					if (pend_reg) begin
						xd_next = `LAT_SYNC_FF; // RL13
						xv_next = 1'b1;
						pend_next = 1'b0;
						fmt_next = LAT_PRE1;
					end else if (fifo_out_valid) begin
						xv_next = 1'b1;
						xd_next = fifo_out.raw ? fifo_out.y : fifo_out.uv;
						fifo_pop = fifo_out.raw;
						fmt_next = fifo_out.raw ? LAT_IDLE : LAT_LUMA;
					end
				end
				LAT_PRE1, LAT_PRE2: begin
					xd_next = `LAT_SYNC_00; // RL13
					xv_next = 1'b1;
					fmt_next = (fmt_reg == LAT_PRE1) ? LAT_PRE2 : LAT_XY;
				end
				LAT_XY: begin
					xd_next = xy_reg; // RL13
					xv_next = 1'b1;
					fmt_next = LAT_IDLE;
				end
				LAT_LUMA: begin
					xd_next = fifo_out.y;
					xv_next = 1'b1;
					fifo_pop = 1'b1;
					fmt_next = LAT_IDLE;
				end
				default: fmt_next = LAT_IDLE;
			endcase
		end
		if (line_start) begin
			pend_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fmt_reg <= LAT_IDLE;
			xd_reg <= 8'h00;
			xy_reg <= 8'h00;
			xv_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			fmt_reg <= fmt_next;
			xd_reg <= xd_next;
			xy_reg <= xy_next;
			xv_reg <= xv_next;
			pend_reg <= pend_next;
		end
	end
	assign expansion_port_data = xd_reg;
	assign expansion_data_qualifier = xv_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_take_mid_uv;
		accept && cur_yuv && in_sample.uv == `LAT_MID;
	endsequence
	sequence s_sav_go;
		fire && fmt_reg == LAT_IDLE && pend_reg;
	endsequence

	property p_clamp;
		@(posedge ref_clk) disable iff (!resetn)
		st_vld_reg |-> st_reg.y inside {[8'h01:8'hFE]} &&
			st_reg.uv inside {[8'h01:8'hFE]};
	endproperty
	a_clamp: assert property (p_clamp) else $error("sample not clamped"); // RL4
	property p_uv_mid;
		@(posedge ref_clk) disable iff (!resetn)
		s_take_mid_uv |=> st_reg.uv == `LAT_MID;
	endproperty
	a_uv_mid: assert property (p_uv_mid) else $error("chroma zero moved"); // RL1
	property p_bri;
		@(posedge ref_clk) disable iff (!resetn)
		accept && cur_yuv && in_sample.y == `LAT_MID &&
			bri_reg inside {[8'h01:8'hFE]} |=> st_reg.y == $past(bri_reg);
	endproperty
	a_bri: assert property (p_bri) else $error("brightness offset wrong"); // RL2
	property p_raw_off;
		@(posedge ref_clk) disable iff (!resetn)
		accept && !cur_yuv && in_sample.comp == `LAT_MID &&
			rofs_reg inside {[8'h01:8'hFE]} |=>
			st_reg.raw && st_reg.y == $past(rofs_reg);
	endproperty
	a_raw_off: assert property (p_raw_off) else $error("raw offset wrong"); // RL3
	property p_active;
		@(posedge ref_clk) disable iff (!resetn)
		cur_type == `LAT_TYPE_ACT_YUV |=> !raw_line_strobe && !vbi_line_strobe;
	endproperty
	a_active: assert property (p_active) else $error("active strobes wrong"); // RL7
	property p_vbi_yuv;
		@(posedge ref_clk) disable iff (!resetn)
		cur_type == `LAT_TYPE_VBI_YUV |=> !raw_line_strobe && vbi_line_strobe;
	endproperty
	a_vbi_yuv: assert property (p_vbi_yuv) else $error("type 6 wrong"); // RL12
	property p_bypass;
		@(posedge ref_clk) disable iff (!resetn)
		raw_line_strobe || vbi_line_strobe |-> comb_bypass;
	endproperty
	a_bypass: assert property (p_bypass) else $error("comb not bypassed"); // RL15
	property p_rest;
		@(posedge ref_clk) disable iff (!resetn)
		(rel < 9'h002 || rel > 9'h017) |-> entry == `LAT_ENTRY_REST;
	endproperty
	a_rest: assert property (p_rest) else $error("rest entry wrong"); // RL8
	property p_nibble;
		@(posedge ref_clk) disable iff (!resetn)
		!field_sel |-> cur_type == tsel_reg[entry][7:4];
	endproperty
	a_nibble: assert property (p_nibble) else $error("field nibble wrong"); // RL9
	property p_sav;
		@(posedge ref_clk) disable iff (!resetn)
		s_sav_go |=> expansion_data_qualifier &&
			expansion_port_data == `LAT_SYNC_FF;
	endproperty
	a_sav: assert property (p_sav) else $error("timing code missing"); // RL13
endmodule : lat_line_typer

//--- verification/lat_xp_sink.sv
// Expansion port consumer taking bytes promptly, slowly or not at all
module lat_xp_sink (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Expansion port
	input wire logic [7:0] xp_data,
	input wire logic xp_qual,
	output logic xp_ready,
	// Pace: 0 prompt, 1 every other cycle, 2 stalled
	input wire logic [1:0] mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	logic tick;
	initial begin
		xp_ready = 1'b0;
		tick = 1'b0;
	end
	// Ready moves only between sampling edges
	always @(negedge ref_clk) begin
		tick <= ~tick;
		xp_ready <= resetn && (mode == 2'h0 || (mode == 2'h1 && tick));
	end
	always @(posedge ref_clk) begin
		if (resetn && xp_qual && xp_ready) begin
			got_q.push_back(xp_data);
		end
	end
endmodule : lat_xp_sink

//--- verification/testbench.sv
// Self-checking bench for the level adjust and line typer block
`include "lat_defs.svh"
module testbench
	import lat_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, resetn, reg_wr, reg_rd, field_id, line_start, in_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, xp_data;
	logic [8:0] line_num;
	lat_ref_t refs;
	lat_sample_t in_sample;
	logic in_ready, raw_s, vbi_s, comb_s, xp_qual, xp_ready;
	logic xh_ref, xv_ref, rt_ctl, rt_sel0, rt_sel1;
	logic [1:0] mode;
	int num_errors, checks;
	logic [7:0] exp_q[$];
	logic [7:0] lv[5] = '{8'h40, 8'h44, 8'h80, 8'h40, 8'h80};
	lat_sample_t smp[8] = '{24'hFF0000, 24'h00FFFF, 24'h7F7F7F, 24'hFA8190,
		24'h808080, 24'h10F010, 24'h017FFE, 24'hC040A0};

	lat_line_typer i_dut (
		.ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .line_num, .field_id, .line_start, .refs, .in_valid,
		.in_ready, .in_sample, .raw_line_strobe(raw_s),
		.vbi_line_strobe(vbi_s), .comb_bypass(comb_s),
		.expansion_port_data(xp_data), .expansion_data_qualifier(xp_qual),
		.xp_ready, .expansion_horiz_ref(xh_ref), .expansion_vert_ref(xv_ref),
		.realtime_control_out(rt_ctl), .realtime_select_out0(rt_sel0),
		.realtime_select_out1(rt_sel1)
	);
	lat_xp_sink i_sink (
		.ref_clk, .resetn, .xp_data, .xp_qual, .xp_ready, .mode
	);

	////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask : rd

	function automatic logic [7:0] adj(input logic [7:0] x,
			input logic [7:0] g, input logic [7:0] o, input int dv);
		int v;
		v = int'(g) * (int'(x) - 128) / dv + int'(o);
		if (v < 1)
			v = 1;
		if (v > 254)
			v = 254;
		return v[7:0];
	endfunction : adj

	task automatic set_off(input logic [8:0] o, input logic f);
		wr(`LAT_LOFS_LO, o[7:0]);
		wr(`LAT_LOFS_HI, {f, 2'b00, o[8], 4'h0});
	endtask : set_off

	task automatic set_line(input logic [8:0] ln, input logic f);
		@(negedge ref_clk);
		line_num = ln;
		field_id = f;
		repeat (2) @(negedge ref_clk);
	endtask : set_line

	task automatic chk_type(input logic [8:0] ln, input logic f,
			input logic [3:0] t);
		logic r;
		logic v;
		r = !(t == 4'h6 || t == 4'hF);
		v = t != 4'hF;
		set_line(ln, f);
		chk({5'h00, raw_s, vbi_s, comb_s}, {5'h00, r, v, r | v});
		rd(`LAT_STATUS, {2'b00, r, v, t});
	endtask : chk_type

	task automatic send(input lat_sample_t s);
		@(negedge ref_clk);
		in_valid = 1'b1;
		in_sample = s;
		#1;
		while (in_ready !== 1'b1) begin
			@(negedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
	endtask : send

	// One line: header bytes, then adjusted samples
	task automatic run_line(input logic [8:0] ln, input logic f,
			input logic [3:0] t, input logic [1:0] pace);
		logic r;
		logic v;
		r = !(t == 4'h6 || t == 4'hF);
		v = t != 4'hF;
		wr(`LAT_TSEL_LAST, {t, t});
		set_line(ln, f);
		i_sink.got_q.delete();
		exp_q = '{8'hFF, 8'h00, 8'h00, {1'b1, f, v, 1'b0, v, f, f ^ v, f ^ v}};
		foreach (smp[i]) begin
			if (r) begin
				exp_q.push_back(adj(smp[i].comp, lv[3], lv[4], 64));
			end else begin
				exp_q.push_back(adj(smp[i].uv, lv[0], 8'h80, 64));
				exp_q.push_back(adj(smp[i].y, lv[1], lv[2], 68));
			end
		end
		mode <= pace;
		line_start = 1'b1;
		@(negedge ref_clk);
		line_start = 1'b0;
		fork
			begin
				foreach (smp[i]) send(smp[i]);
				@(negedge ref_clk);
				in_valid = 1'b0;
			end
			if (pace == 2'h2) begin
				repeat (40) @(negedge ref_clk);
				chk({7'h00, in_ready}, 8'h00);
				mode <= 2'h1;
			end
		join
		for (int n = 0; n < 400 && i_sink.got_q.size() < exp_q.size(); n++)
			@(negedge ref_clk);
		chk(8'(i_sink.got_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) chk(i_sink.got_q[i], exp_q[i]);
	endtask : run_line

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////
	initial begin
		logic e;
		logic er;
		{resetn, reg_wr, reg_rd, field_id, line_start, in_valid} = '0;
		{reg_addr, reg_wdata, line_num, refs, in_sample} = '0;
		mode = 2'h0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1'b1;
		for (int i = 0; i < 5; i++) rd(8'(`LAT_SAT + i), lv[i]);
		rd(`LAT_TSEL_FIRST, 8'hFF);
		rd(8'h70, 8'h00);
		wr(`LAT_STATUS, 8'hAA);
		set_off(9'h003, 1'b0);
		for (int t = 0; t < 16; t++) begin
			wr(`LAT_TSEL_LAST, {t[3:0], ~t[3:0]});
			chk_type(9'd100, 1'b0, t[3:0]);
		end
		chk_type(9'd100, 1'b1, 4'h0);
		wr(`LAT_TSEL_FIRST, 8'h7F);
		wr(8'h56, 8'h6F);
		chk_type(9'd5, 1'b0, 4'h7);
		chk_type(9'd5, 1'b1, 4'hF);
		chk_type(9'd4, 1'b0, 4'hF);
		chk_type(9'd26, 1'b0, 4'h6);
		chk_type(9'd27, 1'b0, 4'hF);
		set_off(9'h006, 1'b1);
		chk_type(9'd8, 1'b1, 4'h7);
		chk_type(9'd8, 1'b0, 4'hF);
		set_off(9'h103, 1'b0);
		chk_type(9'h105, 1'b0, 4'h7);
		chk_type(9'd5, 1'b0, 4'hF);
		set_off(9'h003, 1'b0);
		for (int c = 0; c < 6; c++) begin
			wr(`LAT_RTSEL, {c[1:0], c[2:0], c[2:0]});
			wr(`LAT_XPSEL, {2'b00, c[2:0], c[2:0]});
			for (int b = 0; b < 5; b++) begin
				@(negedge ref_clk);
				refs = lat_ref_t'(5'h10 >> b);
				@(negedge ref_clk);
				e = c < 5 && b == c;
				er = b == (c & 3);
				chk({3'h0, rt_ctl, rt_sel1, rt_sel0, xv_ref, xh_ref},
					{3'h0, er, e, e, e, e});
			end
		end
		run_line(9'd100, 1'b0, 4'hF, 2'h2);
		lv = '{8'h50, 8'h50, 8'hF0, 8'h80, 8'h70};
		for (int i = 0; i < 5; i++) wr(8'(`LAT_SAT + i), lv[i]);
		run_line(9'd100, 1'b1, 4'h6, 2'h1);
		run_line(9'd100, 1'b0, 4'h7, 2'h0);
		wrap_up();
	end

	// Run needs about 500 cycles; allow about fifty times that
	initial begin
		#100000;
		num_errors++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		wrap_up();
	end
endmodule : testbench
